// ### inc/fgi_defines.vh
// Constants for the fuel gauge two-wire target port.
`ifndef FGI_DEFINES_VH
`define FGI_DEFINES_VH

// ----------------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------------
`define FGI_TARGET_ADDR7 7'h36
`define FGI_ADDR_BYTE_WR 8'h6C
`define FGI_ADDR_BYTE_RD 8'h6D
`define FGI_BYTE_BITS 4'h8

// ----------------------------------------------------------------------------
// Register map limits and command word
// ----------------------------------------------------------------------------
`define FGI_WRITE_LAST 9'h04F
`define FGI_CMD_ADDR 9'h0FE
`define FGI_CMD_RESET 16'h5400
`define FGI_PAST_END_BYTE 8'hFF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FGI_CLK_HZ 40000000
`define FGI_SCL_MAX_HZ 400000
`define FGI_SCL_MIN_CYCLES (`FGI_CLK_HZ / `FGI_SCL_MAX_HZ)
`define FGI_SLEEP_CYCLES 100000000

// ----------------------------------------------------------------------------
// Write queue
// ----------------------------------------------------------------------------
`define FGI_FIFO_DEPTH 4
`define FGI_FIFO_WIDTH 24

`endif

// ### core/fgi_target.v
// Two-wire bus target port of the fuel gauge, with its write queue.
`timescale 1ns/1ps
`include "fgi_defines.vh"

// ----------------------------------------------------------------------------
// Write queue
// ----------------------------------------------------------------------------
module fgi_fifo #(
  parameter WIDTH = `FGI_FIFO_WIDTH,
  parameter DEPTH = `FGI_FIFO_DEPTH,
  parameter AW = 2
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // fgi_fifo

// ----------------------------------------------------------------------------
// Target port
// ----------------------------------------------------------------------------
module fgi_target #(
  parameter SLEEP_CYCLES = `FGI_SLEEP_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  output reg [7:0] rd_addr,
  input wire [15:0] rd_data,
  input wire wr_permit,
  output reg wr_valid,
  input wire wr_ready,
  output reg [7:0] wr_addr,
  output reg [15:0] wr_data,
  input wire sleep_permit_bit,
  output reg sleep_state,
  output reg reset_pulse
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RECV = 5'h02;
  localparam [4:0] ST_SACK = 5'h04;
  localparam [4:0] ST_SEND = 5'h08;
  localparam [4:0] ST_HACK = 5'h10;

  // Synchronisers; the first stage feeds only the second.
  reg scl_m_reg;
  reg scl_s_reg;
  reg scl_d_reg;
  reg sda_m_reg;
  reg sda_s_reg;
  reg sda_d_reg;

  reg [4:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [8:0] ptr_reg;
  reg got_addr_reg;
  reg got_ptr_reg;
  reg rw_reg;
  reg hi_ok_reg;
  reg [7:0] hi_byte_reg;
  reg host_nak_reg;
  reg [31:0] low_cnt_reg;

  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [7:0] tx_byte;
  wire [8:0] ptr_inc;
  wire is_cmd;
  wire can_store;

  wire q_in_ready;
  wire q_out_valid;
  wire [23:0] q_out_data;
  reg q_in_valid;
  reg [23:0] q_in_data;
  wire q_pop;

  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  // Data moving while the clock stays high is framing, never data.
  assign start_cond = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_cond = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  assign ptr_inc = ptr_reg + 9'h001;
  // Past the end of the map the read data is all ones.
  assign tx_byte = ptr_reg[8] ? `FGI_PAST_END_BYTE :
                   (ptr_reg[0] ? rd_data[7:0] : rd_data[15:8]);
  assign is_cmd = ({ptr_reg[8:1], 1'b0} == `FGI_CMD_ADDR) &&
                  ({hi_byte_reg, shift_reg} == `FGI_CMD_RESET);
  assign can_store = hi_ok_reg && ptr_reg[0] && (ptr_reg <= `FGI_WRITE_LAST) &&
                     wr_permit;
  assign q_pop = q_out_valid & (~wr_valid | wr_ready);

  // --------------------------------------------------------------------------
  // Input sampling
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Bus protocol engine
  // --------------------------------------------------------------------------
  // The engine only ever reacts to clock edges and start/stop conditions made by the controller and
  // holds no rate setting, so any rate slow enough to be sampled works.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 9'h000;
      got_addr_reg <= 1'b0;
      got_ptr_reg <= 1'b0;
      rw_reg <= 1'b0;
      hi_ok_reg <= 1'b0;
      hi_byte_reg <= 8'h00;
      host_nak_reg <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      rd_addr <= 8'h00;
      q_in_valid <= 1'b0;
      q_in_data <= 24'h000000;
      reset_pulse <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      rd_addr <= ptr_reg[7:0];
      q_in_valid <= 1'b0;
      reset_pulse <= 1'b0;
      if (start_cond) begin
        // A repeated start closes the open transaction; the pointer survives.
        state_reg <= ST_RECV;
        bit_cnt_reg <= 4'h0;
        got_addr_reg <= 1'b0;
        got_ptr_reg <= 1'b0;
        hi_ok_reg <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        sda_oe_n <= 1'b1;
        hi_ok_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          ST_RECV: begin
            if (scl_rise && bit_cnt_reg != `FGI_BYTE_BITS) begin
              shift_reg <= {shift_reg[6:0], sda_s_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `FGI_BYTE_BITS) begin
              if (!got_addr_reg) begin
                if (shift_reg[7:1] == `FGI_TARGET_ADDR7) begin
                  got_addr_reg <= 1'b1;
                  rw_reg <= shift_reg[0];
                  state_reg <= ST_SACK;
                  sda_oe_n <= 1'b0;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (!got_ptr_reg) begin
                got_ptr_reg <= 1'b1;
                ptr_reg <= {1'b0, shift_reg};
                hi_ok_reg <= 1'b0;
                state_reg <= ST_SACK;
                sda_oe_n <= 1'b0;
              end else begin
                state_reg <= ST_SACK;
                if (ptr_reg[0] == 1'b0) begin
                  hi_byte_reg <= shift_reg;
                  hi_ok_reg <= 1'b1;
                  ptr_reg <= ptr_inc;
                  sda_oe_n <= 1'b0;
                end else if (hi_ok_reg && is_cmd) begin
                  // No acknowledge for the reset command's last byte.
                  reset_pulse <= 1'b1;
                  hi_ok_reg <= 1'b0;
                  ptr_reg <= ptr_inc;
                  sda_oe_n <= 1'b1;
                end else if (can_store && !q_in_ready) begin
                  // A full queue refuses the byte, so nothing unacked is kept.
                  hi_ok_reg <= 1'b0;
                  ptr_reg <= ptr_inc;
                  sda_oe_n <= 1'b1;
                end else begin
                  if (can_store) begin
                    q_in_valid <= 1'b1;
                    q_in_data <= {ptr_reg[7:1], 1'b0, hi_byte_reg, shift_reg};
                  end
                  hi_ok_reg <= 1'b0;
                  ptr_reg <= ptr_inc;
                  sda_oe_n <= 1'b0;
                end
              end
            end
          end
          ST_SACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                // From the address acknowledge onward the device owns data.
                state_reg <= ST_SEND;
                shift_reg <= {tx_byte[6:0], 1'b0};
                sda_oe_n <= tx_byte[7];
                bit_cnt_reg <= 4'h1;
              end else begin
                state_reg <= ST_RECV;
                sda_oe_n <= 1'b1;
                bit_cnt_reg <= 4'h0;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt_reg == `FGI_BYTE_BITS) begin
                state_reg <= ST_HACK;
                sda_oe_n <= 1'b1;
                ptr_reg <= ptr_reg[8] ? ptr_reg : ptr_inc;
              end else begin
                sda_oe_n <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_HACK: begin
            if (scl_rise) begin
              host_nak_reg <= sda_s_reg;
            end else if (scl_fall) begin
              if (host_nak_reg) begin
                state_reg <= ST_IDLE;
                sda_oe_n <= 1'b1;
              end else begin
                state_reg <= ST_SEND;
                shift_reg <= {tx_byte[6:0], 1'b0};
                sda_oe_n <= tx_byte[7];
                bit_cnt_reg <= 4'h1;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Write queue and output stage
  // --------------------------------------------------------------------------
  // The queue decouples the word store from the register file, which may be
  // busy; the ready term feeds back into the acknowledge decision.
  fgi_fifo #(
    .WIDTH(24),
    .DEPTH(`FGI_FIFO_DEPTH),
    .AW(2)
  ) u_queue (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(q_in_data),
    .out_valid(q_out_valid),
    .out_ready(~wr_valid | wr_ready),
    .out_data(q_out_data)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 16'h0000;
    end else if (q_pop) begin
      wr_valid <= 1'b1;
      wr_addr <= q_out_data[23:16];
      wr_data <= q_out_data[15:0];
    end else if (wr_ready) begin
      wr_valid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Sleep on a long bus-low
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 32'h00000000;
      sleep_state <= 1'b0;
    end else begin
      if (scl_s_reg | sda_s_reg) begin
        low_cnt_reg <= 32'h00000000;
      end else if (low_cnt_reg != SLEEP_CYCLES) begin
        low_cnt_reg <= low_cnt_reg + 32'h00000001;
      end
      if (sleep_state && ((scl_s_reg & ~scl_d_reg) | (sda_s_reg & ~sda_d_reg))) begin
        sleep_state <= 1'b0;
      end else if (sleep_permit_bit && !scl_s_reg && !sda_s_reg &&
                   low_cnt_reg == SLEEP_CYCLES - 1) begin
        sleep_state <= 1'b1;
      end
    end
  end
endmodule // fgi_target

// ### verif/fgi_host_model.sv
// Behavioural two-wire bus controller that drives the target port.
`timescale 1ns/1ps
module fgi_host_model (
  output logic scl,
  output logic sda_rel,
  input wire logic sda,
  output logic [7:0] rx_byte,
  output logic rx_tick
);
  localparam int Q = 50;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    rx_byte = 8'h00;
    rx_tick = 1'b0;
  end
  // The 7 ns offset keeps pin changes away from the system clock edges.
  task automatic start();
    #7;
    #Q sda_rel = 1'b1;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_rel = 1'b0;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b1;
  endtask
  task automatic bitx(input logic b, output logic r);
    #Q sda_rel = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic last);
    logic r;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, r);
      d = {d[6:0], r};
    end
    bitx(last, r);
    rx_byte = d;
    rx_tick = ~rx_tick;
  endtask
  task automatic bus_low();
    #7;
    #Q sda_rel = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic bus_idle();
    #Q scl = 1'b1;
    #Q sda_rel = 1'b1;
  endtask
endmodule // fgi_host_model

// ### verif/fgi_target_chk.sv
// Concurrent checks on the ports of the two-wire target port.
`timescale 1ns/1ps
module fgi_target_chk #(
  parameter SLEEP_CYCLES = 50
) (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire [7:0] rd_addr,
  input wire [15:0] rd_data,
  input wire wr_permit,
  input wire wr_valid,
  input wire wr_ready,
  input wire [7:0] wr_addr,
  input wire [15:0] wr_data,
  input wire sleep_permit_bit,
  input wire sleep_state,
  input wire reset_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  oe_clk_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data pin changed while clock high");
  pulse_single_a: assert property (reset_pulse |=> !reset_pulse)
    else $error("reset pulse longer than one cycle");
  pulse_nak_a: assert property (reset_pulse |-> sda_oe_n)
    else $error("reset command acknowledged");
  wr_hold_a: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable({wr_addr, wr_data}))
    else $error("write request dropped or changed");
  wr_even_a: assert property (wr_valid |-> !wr_addr[0])
    else $error("odd word address");
  wr_range_a: assert property (wr_valid |-> wr_addr < 8'h50)
    else $error("write past writable end");
  sleep_entry_a: assert property ($rose(sleep_state) |->
    !scl_in && !sda_in && sleep_permit_bit)
    else $error("sleep without cause");
  sleep_wake_a: assert property (sleep_state && $rose(scl_in) |-> ##[1:6] !sleep_state)
    else $error("no wake on clock rise");
  // Run of both lines low as seen at the pins, so early sleep entry shows.
  logic [31:0] low_run;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_run <= 32'h00000000;
    end else if (scl_in || sda_in) begin
      low_run <= 32'h00000000;
    end else begin
      low_run <= low_run + 32'h00000001;
    end
  end
  sleep_delay_a: assert property ($rose(sleep_state) |-> low_run >= SLEEP_CYCLES)
    else $error("sleep before the bus-low interval");
endmodule // fgi_target_chk
bind fgi_target fgi_target_chk #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .rd_addr(rd_addr), .rd_data(rd_data), .wr_permit(wr_permit),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
  .sleep_permit_bit(sleep_permit_bit), .sleep_state(sleep_state), .reset_pulse(reset_pulse));

// ### verif/fuel_gauge_i2c_target_port_bench.sv
// Self-checking bench for the fuel gauge two-wire target port.
`timescale 1ns/1ps
module fuel_gauge_i2c_target_port_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_ready = 1'b0;
  logic sleep_permit_bit = 1'b0;
  logic stall = 1'b0;
  wire scl, sda_rel, sda_out, sda_oe_n, wr_valid, sleep_state, reset_pulse, rx_tick;
  wire [7:0] rd_addr, wr_addr, rx_byte;
  wire [15:0] wr_data;
  logic [15:0] mem [0:127];
  logic [23:0] wr_q[$];
  logic [7:0] rd_q[$];
  int error_cnt = 0;
  int checked = 0;
  int seed = 47037;
  int cyc = 0;
  int pulses = 0;
  // Pull-up on the data line: released by all parties reads high.
  wire sda = sda_rel & (sda_oe_n | sda_out);
  wire wr_permit = (rd_addr[7:1] != 7'h04);
  wire [15:0] rd_data = mem[rd_addr[7:1]];
  fgi_target #(.SLEEP_CYCLES(50)) DUT (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .rd_addr(rd_addr), .rd_data(rd_data), .wr_permit(wr_permit),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .sleep_permit_bit(sleep_permit_bit), .sleep_state(sleep_state),
    .reset_pulse(reset_pulse));
  fgi_host_model host (.scl(scl), .sda_rel(sda_rel), .sda(sda), .rx_byte(rx_byte),
    .rx_tick(rx_tick));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    wr_ready <= !stall && ($random(seed) % 2 != 0);
    if (reset_pulse === 1'b1) pulses++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      check({wr_addr, wr_data}, wr_q.size() ? wr_q.pop_front() : ~{wr_addr, wr_data});
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  always @(rx_tick) begin
    if (rd_q.size() != 0) check({16'h0, rx_byte}, {16'h0, rd_q.pop_front()});
  end
  task automatic open_wr(input logic [7:0] ptr);
    logic a;
    host.start();
    host.wbyte(8'h6C, a);
    check(24'(a), 24'h0);
    host.wbyte(ptr, a);
    check(24'(a), 24'h0);
  endtask
  task automatic write(input logic [7:0] ptr, input int nb);
    logic a;
    logic [7:0] hi, b, p;
    open_wr(ptr);
    for (int i = 0; i < nb; i++) begin
      b = 8'($random(seed));
      p = ptr + 8'(i);
      // The word is noted before its last byte goes out, as it may leave at once.
      if (p[0] && p <= 8'h4F && p[7:1] != 7'h04) wr_q.push_back({p - 8'h01, hi, b});
      host.wbyte(b, a);
      check(24'(a), 24'h0);
      hi = b;
    end
    host.stop();
  endtask
  task automatic read(input logic [7:0] ptr, input int nb);
    logic a;
    logic [8:0] p;
    open_wr(ptr);
    host.start();
    host.wbyte(8'h6D, a);
    check(24'(a), 24'h0);
    for (int i = 0; i < nb; i++) begin
      p = {1'b0, ptr} + 9'(i);
      rd_q.push_back(p[8] ? 8'hFF : p[0] ? mem[p[7:1]][7:0] : mem[p[7:1]][15:8]);
      host.rbyte(i == nb - 1);
    end
    host.stop();
  endtask
  initial begin
    logic a;
    int n;
    for (int i = 0; i < 128; i++) mem[i] = 16'($random(seed));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    host.start();
    host.wbyte(8'h5A, a);
    check(24'(a), 24'h1);
    host.wbyte(8'h00, a);
    check(24'(a), 24'h1);
    host.stop();
    write(8'h0A, 4);
    write(8'h08, 2);
    write(8'h10, 1);
    write(8'h4C, 6);
    read(8'h40, 3);
    read(8'hFE, 4);
    // The consumer stalls, so the queue must fill and refuse a word.
    stall <= 1'b1;
    open_wr(8'h20);
    n = 0;
    a = 1'b0;
    while (a == 1'b0 && n < 8) begin
      host.wbyte(8'h11, a);
      host.wbyte(8'(n), a);
      if (a == 1'b0) wr_q.push_back({8'h20 + 8'(2 * n), 8'h11, 8'(n)});
      n++;
    end
    host.stop();
    check(24'(a), 24'h1);
    check(24'(n >= 5), 24'h1);
    stall <= 1'b0;
    repeat (300) @(posedge clk);
    check(24'(wr_q.size()), 24'h0);
    // The refused word's address is written again, with new data, once the consumer has drained the queue.
    write(8'h20 + 8'(2 * (n - 1)), 2);
    open_wr(8'hFE);
    host.wbyte(8'h54, a);
    check(24'(a), 24'h0);
    host.wbyte(8'h00, a);
    check(24'(a), 24'h1);
    host.stop();
    repeat (10) @(posedge clk);
    check(24'(pulses), 24'h1);
    @(posedge clk);
    sleep_permit_bit <= 1'b1;
    host.bus_low();
    repeat (80) @(posedge clk);
    check(24'(sleep_state), 24'h1);
    host.bus_idle();
    repeat (10) @(posedge clk);
    check(24'(sleep_state), 24'h0);
    check(24'(wr_q.size() + rd_q.size()), 24'h0);
    end_of_test();
  end
endmodule // fuel_gauge_i2c_target_port_bench
